// *** design/eeacc_mem.v ***
// byte-wide storage array with registered read data
`timescale 1ns/1ps
module eeacc_mem #(
    parameter DATA_W = 8,
    parameter ADDR_W = 11
) (
    input  wire              clk,
    input  wire              wr_en,
    input  wire              rd_en,
    input  wire [ADDR_W-1:0] addr,
    input  wire [DATA_W-1:0] wdata,
    output reg  [DATA_W-1:0] rdata
);

    reg [DATA_W-1:0] array_reg [0:(1<<ADDR_W)-1];

    // no reset: contents are nonvolatile by intent
    always @(posedge clk) begin
        if (wr_en) begin
            array_reg[addr] <= wdata;
        end
        if (rd_en) begin
            rdata <= array_reg[addr];
        end
    end

endmodule // eeacc_mem

// *** design/eeacc_top.v ***
// register interface of the byte-wide nonvolatile array, reached over axi4-lite
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "eeacc_regs.vh"
module eeacc_top #(
    parameter               LARGE_ARRAY  = 1,
    parameter [15:0]        WRITE_CYCLES = `EEACC_WRITE_CYCLES
) (
    input  wire                       SYS_CLK,
    input  wire                       RESET,
    input  wire [`EEACC_BUS_AW-1:0]   S_AXI_AWADDR,
    input  wire                       S_AXI_AWVALID,
    output wire                       S_AXI_AWREADY,
    input  wire [`EEACC_DATA_W-1:0]   S_AXI_WDATA,
    input  wire [3:0]                 S_AXI_WSTRB,
    input  wire                       S_AXI_WVALID,
    output wire                       S_AXI_WREADY,
    output reg  [1:0]                 S_AXI_BRESP,
    output reg                        S_AXI_BVALID,
    input  wire                       S_AXI_BREADY,
    input  wire [`EEACC_BUS_AW-1:0]   S_AXI_ARADDR,
    input  wire                       S_AXI_ARVALID,
    output wire                       S_AXI_ARREADY,
    output reg  [`EEACC_DATA_W-1:0]   S_AXI_RDATA,
    output reg  [1:0]                 S_AXI_RRESP,
    output reg                        S_AXI_RVALID,
    input  wire                       S_AXI_RREADY,
    input  wire                       GLOBAL_IRQ_ENABLE,
    output wire                       NVM_READY_IRQ,
    output wire                       WRITE_IN_PROGRESS
);

    ////////////////////////////////////////////////////////////////////////////
    // sequencer states

    localparam [2:0] ST_IDLE  = 3'b001;
    localparam [2:0] ST_READ  = 3'b010;
    localparam [2:0] ST_WRITE = 3'b100;

    localparam       MEM_AW   = LARGE_ARRAY ? `EEACC_ADDR_W : `EEACC_ADDR_W - 1;

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    reg  [`EEACC_BUS_AW-1:0]  aw_addr_reg;
    reg                       aw_held_reg;
    reg  [`EEACC_DATA_W-1:0]  w_data_reg;
    reg  [3:0]                w_strb_reg;
    reg                       w_held_reg;

    reg  [`EEACC_ADDR_W-1:0]  nvm_address_reg;
    reg  [`EEACC_BYTE_W-1:0]  nvm_data_byte_reg;
    reg                       ready_irq_enable_reg;
    reg                       master_write_enable_reg;
    reg  [2:0]                state_reg;
    reg  [2:0]                state_next;
    reg  [15:0]               wait_cnt_reg;

    wire                      wr_fire;
    wire [7:0]                wr_index;
    wire [7:0]                rd_index;
    wire                      wr_lane0;
    wire                      wr_mapped;
    wire                      rd_mapped;
    wire                      ctl_write;
    wire                      start_read;
    wire                      start_write;
    wire                      write_in_progress_enable;
    wire [`EEACC_BYTE_W-1:0]  wbyte;
    wire [MEM_AW-1:0]         mem_addr;
    wire [`EEACC_BYTE_W-1:0]  mem_rdata;
    wire [`EEACC_BYTE_W-1:0]  control_view;
    wire [`EEACC_BYTE_W-1:0]  addr_high_view;
    reg  [`EEACC_BYTE_W-1:0]  rd_byte;

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite write channel: address and data taken in either order

    assign S_AXI_AWREADY = ~aw_held_reg & ~S_AXI_BVALID;
    assign S_AXI_WREADY  = ~w_held_reg & ~S_AXI_BVALID;
    assign wr_fire       = aw_held_reg & w_held_reg & ~S_AXI_BVALID;
    assign wr_index      = aw_addr_reg[`EEACC_BUS_AW-1:2];
    assign wr_lane0      = w_strb_reg[0];
    assign wbyte         = w_data_reg[`EEACC_BYTE_W-1:0];
    assign wr_mapped     = (wr_index == `EEACC_IDX_ADDR_LOW)  |
                           (wr_index == `EEACC_IDX_ADDR_HIGH) |
                           (wr_index == `EEACC_IDX_DATA_BYTE) |
                           (wr_index == `EEACC_IDX_CONTROL);

    always @(posedge SYS_CLK) begin
        if (RESET) begin
            aw_addr_reg  <= {`EEACC_BUS_AW{1'b0}};
            aw_held_reg  <= 1'b0;
            w_data_reg   <= `EEACC_RST_WORD;
            w_strb_reg   <= 4'h0;
            w_held_reg   <= 1'b0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP  <= `EEACC_RESP_OKAY;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_addr_reg <= S_AXI_AWADDR;
                aw_held_reg <= 1'b1;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_data_reg <= S_AXI_WDATA;
                w_strb_reg <= S_AXI_WSTRB;
                w_held_reg <= 1'b1;
            end
            if (wr_fire) begin
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= wr_mapped ? `EEACC_RESP_OKAY : `EEACC_RESP_SLVERR;
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // access sequencer

    assign write_in_progress_enable = (state_reg == ST_WRITE);
    assign WRITE_IN_PROGRESS        = write_in_progress_enable;
    assign ctl_write = wr_fire & wr_lane0 & (wr_index == `EEACC_IDX_CONTROL);
    // a new access is ignored while one is still running
    assign start_read  = ctl_write & wbyte[`EEACC_CTL_READ] & (state_reg == ST_IDLE);
    assign start_write = ctl_write & wbyte[`EEACC_CTL_WIP] & ~wbyte[`EEACC_CTL_READ] &
                         master_write_enable_reg & (state_reg == ST_IDLE);

    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (start_read) begin
                    state_next = ST_READ;
                end else if (start_write) begin
                    state_next = ST_WRITE;
                end
            end
            ST_READ: begin
                state_next = ST_IDLE;
            end
            ST_WRITE: begin
                if (wait_cnt_reg == 16'h0001) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always @(posedge SYS_CLK) begin
        if (RESET) begin
            state_reg    <= ST_IDLE;
            wait_cnt_reg <= 16'h0000;
        end else begin
            state_reg <= state_next;
            if (start_write) begin
                wait_cnt_reg <= WRITE_CYCLES;
            end else if (wait_cnt_reg != 16'h0000) begin
                wait_cnt_reg <= wait_cnt_reg - 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // storage array

    // small variant drops the top address bit from the decode
    assign mem_addr = nvm_address_reg[MEM_AW-1:0];

    eeacc_mem #(
        .DATA_W (`EEACC_BYTE_W),
        .ADDR_W (MEM_AW)
    ) u_mem (
        .clk   (SYS_CLK),
        .wr_en (start_write),
        .rd_en (start_read),
        .addr  (mem_addr),
        .wdata (nvm_data_byte_reg),
        .rdata (mem_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////
    // software registers

    // address resets to zero although software may not rely on any value
    always @(posedge SYS_CLK) begin
        if (RESET) begin
            nvm_address_reg         <= `EEACC_RST_ADDR;
            nvm_data_byte_reg       <= `EEACC_RST_BYTE;
            ready_irq_enable_reg    <= 1'b0;
            master_write_enable_reg <= 1'b0;
        end else begin
            if (wr_fire && wr_lane0 && wr_index == `EEACC_IDX_ADDR_LOW) begin
                nvm_address_reg[`EEACC_BYTE_W-1:0] <= wbyte;
            end
            if (wr_fire && wr_lane0 && wr_index == `EEACC_IDX_ADDR_HIGH) begin
                nvm_address_reg[`EEACC_ADDR_TOP-1:`EEACC_BYTE_W] <=
                    wbyte[`EEACC_ADDR_HIGH_W-2:0];
                nvm_address_reg[`EEACC_ADDR_TOP] <=
                    (LARGE_ARRAY != 0) & wbyte[`EEACC_ADDR_HIGH_W-1];
            end
            // a finished fetch wins over a software write in the same cycle
            if (state_reg == ST_READ) begin
                nvm_data_byte_reg <= mem_rdata;
            end else if (wr_fire && wr_lane0 && wr_index == `EEACC_IDX_DATA_BYTE) begin
                nvm_data_byte_reg <= wbyte;
            end
            if (ctl_write) begin
                ready_irq_enable_reg <= wbyte[`EEACC_CTL_RIE];
            end
            // master enable is one-shot: it is used up by the write it allows
            if (start_write) begin
                master_write_enable_reg <= 1'b0;
            end else if (ctl_write) begin
                master_write_enable_reg <= wbyte[`EEACC_CTL_MASTER];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read channel

    assign addr_high_view = {5'h00, nvm_address_reg[`EEACC_ADDR_TOP:`EEACC_BYTE_W]};
    assign control_view   = {4'h0,
                             ready_irq_enable_reg,
                             master_write_enable_reg,
                             write_in_progress_enable,
                             state_reg == ST_READ};
    assign rd_index       = S_AXI_ARADDR[`EEACC_BUS_AW-1:2];
    assign rd_mapped      = (rd_index == `EEACC_IDX_ADDR_LOW)  |
                            (rd_index == `EEACC_IDX_ADDR_HIGH) |
                            (rd_index == `EEACC_IDX_DATA_BYTE) |
                            (rd_index == `EEACC_IDX_CONTROL);
    assign S_AXI_ARREADY  = ~S_AXI_RVALID;

    always @* begin
        case (rd_index)
            `EEACC_IDX_ADDR_LOW:  rd_byte = nvm_address_reg[`EEACC_BYTE_W-1:0];
            `EEACC_IDX_ADDR_HIGH: rd_byte = addr_high_view;
            `EEACC_IDX_DATA_BYTE: rd_byte = nvm_data_byte_reg;
            `EEACC_IDX_CONTROL:   rd_byte = control_view;
            default:              rd_byte = `EEACC_RST_BYTE;
        endcase
    end

    always @(posedge SYS_CLK) begin
        if (RESET) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA  <= `EEACC_RST_WORD;
            S_AXI_RRESP  <= `EEACC_RESP_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA  <= {24'h000000, rd_byte};
            S_AXI_RRESP  <= rd_mapped ? `EEACC_RESP_OKAY : `EEACC_RESP_SLVERR;
        end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // ready interrupt: a level, not a pulse, so the handler must disable it

    assign NVM_READY_IRQ = ready_irq_enable_reg & GLOBAL_IRQ_ENABLE &
                           ~write_in_progress_enable;

endmodule // eeacc_top

// *** pkg/eeacc_regs.vh ***
// register map, field positions and timing constants of the nonvolatile access block
`ifndef EEACC_REGS_VH
`define EEACC_REGS_VH

// bus geometry
`define EEACC_BUS_AW          10
`define EEACC_DATA_W          32
`define EEACC_BYTE_W          8

// register indices; byte address is four times the index
`define EEACC_IDX_ADDR_LOW    8'h21
`define EEACC_IDX_ADDR_HIGH   8'h22
`define EEACC_IDX_DATA_BYTE   8'h23
`define EEACC_IDX_CONTROL     8'h24

// address field
`define EEACC_ADDR_W          11
`define EEACC_ADDR_TOP        10
`define EEACC_ADDR_HIGH_W     3

// control field positions
`define EEACC_CTL_READ        0
`define EEACC_CTL_WIP         1
`define EEACC_CTL_MASTER      2
`define EEACC_CTL_RIE         3

// axi responses
`define EEACC_RESP_OKAY       2'h0
`define EEACC_RESP_SLVERR     2'h2

// reset values
`define EEACC_RST_BYTE        8'h00
`define EEACC_RST_ADDR        11'h000
`define EEACC_RST_WORD        32'h00000000

// timing: array write time in system clock cycles
`define EEACC_WRITE_CYCLES    16
`define EEACC_CNT_W           16

`endif

// *** tb/eeacc_top_checker.sv ***
// port-level assertions for the nonvolatile access register block
`timescale 1ns/1ps
`include "eeacc_regs.vh"
module eeacc_top_checker #(
    parameter [15:0] WRITE_CYCLES = `EEACC_WRITE_CYCLES
) (
    input wire                     SYS_CLK,
    input wire                     RESET,
    input wire [`EEACC_BUS_AW-1:0] S_AXI_AWADDR,
    input wire                     S_AXI_AWVALID,
    input wire                     S_AXI_AWREADY,
    input wire [`EEACC_DATA_W-1:0] S_AXI_WDATA,
    input wire [3:0]               S_AXI_WSTRB,
    input wire                     S_AXI_WVALID,
    input wire                     S_AXI_WREADY,
    input wire [1:0]               S_AXI_BRESP,
    input wire                     S_AXI_BVALID,
    input wire                     S_AXI_BREADY,
    input wire [`EEACC_BUS_AW-1:0] S_AXI_ARADDR,
    input wire                     S_AXI_ARVALID,
    input wire                     S_AXI_ARREADY,
    input wire [`EEACC_DATA_W-1:0] S_AXI_RDATA,
    input wire [1:0]               S_AXI_RRESP,
    input wire                     S_AXI_RVALID,
    input wire                     S_AXI_RREADY,
    input wire                     GLOBAL_IRQ_ENABLE,
    input wire                     NVM_READY_IRQ,
    input wire                     WRITE_IN_PROGRESS
);
////////////////////////////////////////////////////////////////////////////////
// length of each busy phase; one cycle of slack since the start edge may count
reg [15:0] wip_cnt_reg;
always @(posedge SYS_CLK) begin
    if (RESET)
        wip_cnt_reg <= 16'h0000;
    else
        wip_cnt_reg <= WRITE_IN_PROGRESS ? wip_cnt_reg + 16'h0001 : 16'h0000;
end
wire ar_hs = S_AXI_ARVALID && S_AXI_ARREADY;
default clocking cb @(posedge SYS_CLK); endclocking
default disable iff (RESET);
////////////////////////////////////////////////////////////////////////////////
a_irq_cause: assert property (NVM_READY_IRQ |->
    GLOBAL_IRQ_ENABLE && !WRITE_IN_PROGRESS)
    else $error("ready request without enable or while busy");
a_high_zero: assert property (ar_hs && S_AXI_ARADDR == 10'h088 |=>
    S_AXI_RDATA[7:3] == 5'h00)
    else $error("reserved address bits read nonzero");
a_ctl_zero: assert property (ar_hs && S_AXI_ARADDR == 10'h090 |=>
    S_AXI_RDATA[7:4] == 4'h0)
    else $error("reserved control bits read nonzero");
a_byte_lane: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h000000)
    else $error("read data above the byte lane");
a_wip_length: assert property ($fell(WRITE_IN_PROGRESS) |->
    wip_cnt_reg >= WRITE_CYCLES && wip_cnt_reg <= WRITE_CYCLES + 16'h0001)
    else $error("write busy phase of wrong length");
a_read_answer: assert property (ar_hs |=> S_AXI_RVALID)
    else $error("read answer late");
a_ar_refuse: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read address taken while answer pending");
a_b_refuse: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write taken while response pending");
c_read: cover property (ar_hs);
c_write: cover property (S_AXI_BVALID);
c_wip: cover property ($rose(WRITE_IN_PROGRESS));
c_irq: cover property ($rose(NVM_READY_IRQ));
endmodule // eeacc_top_checker
bind eeacc_top eeacc_top_checker #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (
    .SYS_CLK(SYS_CLK), .RESET(RESET),
    .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
    .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
    .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID),
    .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
    .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RREADY(S_AXI_RREADY), .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE),
    .NVM_READY_IRQ(NVM_READY_IRQ), .WRITE_IN_PROGRESS(WRITE_IN_PROGRESS)
);

// *** tb/eeacc_top_test.sv ***
// self-checking bench of the nonvolatile access register block
`timescale 1ns/1ps
`include "eeacc_regs.vh"
module eeacc_top_test;
localparam ADL = 10'h084, ADH = 10'h088, DAT = 10'h08C, CTL = 10'h090;
localparam IRQ_F = 1'b0, WIP_F = 1'b1;
logic        clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, arv = 1'b0, gie = 1'b0;
logic [9:0]  awa = 10'h000, ara = 10'h000;
logic [31:0] wd = 32'h00000000;
wire         awr, wrd, bv, arr, rv, irq, wip;
wire [1:0]   br, rr;
wire [31:0]  rdt;
integer      fails = 0, tests_run = 0, i;
// rows: address, byte written, byte read back
logic [25:0] rows [0:4] = '{{ADL, 8'hA5, 8'hA5}, {ADH, 8'hFF, 8'h07}, {DAT, 8'h3C, 8'h3C},
                            {CTL, 8'hF8, 8'h08}, {CTL, 8'h00, 8'h00}};
// response ready held high: legal, and avoids reassigning it between transfers
eeacc_top #(.LARGE_ARRAY(1), .WRITE_CYCLES(16'h0004)) uut (
    .SYS_CLK(clk), .RESET(rst), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd),
    .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(1'b1), .S_AXI_ARADDR(ara),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdt), .S_AXI_RRESP(rr),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(1'b1), .GLOBAL_IRQ_ENABLE(gie), .NVM_READY_IRQ(irq),
    .WRITE_IN_PROGRESS(wip));
always #50 clk = ~clk;
////////////////////////////////////////////////////////////////////////////////
task complete_run;
    $display("compared %0d, mismatched %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
        $display("bench passed");
    else
        $display("bench failed");
    $finish;
endtask
task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
        fails = fails + 1;
        $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
endtask
// a flag is looked at on the next edge, so it shows what the last edge left behind
task chk_flag(input logic sel_wip, input logic exp);
    @(posedge clk);
    chk({31'h0, sel_wip ? wip : irq}, {31'h0, exp});
endtask
task step(inout integer n);
    @(posedge clk);
    n = n + 1;
    if (n > 100) begin
        chk(32'h1, 32'h0);
        complete_run;
    end
endtask
task wr(input logic [9:0] a, input logic [7:0] d, input logic [1:0] er);
    integer n;
    n = 0;
    awa <= a;
    wd <= {24'h000000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
        step(n);
        if (awv && awr)
            awv <= 1'b0;
        if (wv && wrd)
            wv <= 1'b0;
    end while (bv !== 1'b1);
    chk({30'h0, br}, {30'h0, er});
endtask
task rd(input logic [9:0] a, input logic [7:0] e, input logic [1:0] er);
    integer n;
    n = 0;
    ara <= a;
    arv <= 1'b1;
    do begin
        step(n);
        if (arv && arr)
            arv <= 1'b0;
    end while (rv !== 1'b1);
    chk(rdt, {24'h000000, e});
    chk({30'h0, rr}, {30'h0, er});
endtask
task nvw(input logic [7:0] hi, input logic [7:0] d);
    integer n;
    n = 0;
    wr(ADL, 8'h00, 2'h0);
    wr(ADH, hi, 2'h0);
    wr(DAT, d, 2'h0);
    wr(CTL, 8'h0C, 2'h0);
    wr(CTL, 8'h0A, 2'h0);
    chk_flag(WIP_F, 1'b1);
    chk_flag(IRQ_F, 1'b0);
    while (wip !== 1'b0)
        step(n);
    chk_flag(IRQ_F, 1'b1);
endtask
// low address is left from the last write: it must have held
task nvr(input logic [7:0] hi, input logic [7:0] e);
    wr(ADH, hi, 2'h0);
    wr(DAT, 8'hEE, 2'h0);
    wr(CTL, 8'h09, 2'h0);
    rd(DAT, e, 2'h0);
endtask
////////////////////////////////////////////////////////////////////////////////
initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    chk_flag(IRQ_F, 1'b0);
    chk_flag(WIP_F, 1'b0);
    rd(CTL, 8'h00, 2'h0);
    $display("test reset done");
    for (i = 0; i < 5; i = i + 1) begin
        wr(rows[i][25:16], rows[i][15:8], 2'h0);
        rd(rows[i][25:16], rows[i][7:0], 2'h0);
    end
    $display("test rows done");
    wr(10'h0FC, 8'hFF, 2'h2);
    rd(10'h0FC, 8'h00, 2'h2);
    $display("test unmapped done");
    gie <= 1'b1;
    nvw(8'h04, 8'h5A);
    nvw(8'h00, 8'hC3);
    nvr(8'h04, 8'h5A);
    nvr(8'h00, 8'hC3);
    rd(ADL, 8'h00, 2'h0);
    $display("test array done");
    gie <= 1'b0;
    chk_flag(IRQ_F, 1'b0);
    gie <= 1'b1;
    chk_flag(IRQ_F, 1'b1);
    wr(CTL, 8'h00, 2'h0);
    chk_flag(IRQ_F, 1'b0);
    $display("test interrupt done");
    // reset cut into a running array write; held three edges so the busy fall lies inside it
    wr(CTL, 8'h0C, 2'h0);
    wr(CTL, 8'h0A, 2'h0);
    chk_flag(WIP_F, 1'b1);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    chk_flag(WIP_F, 1'b0);
    chk_flag(IRQ_F, 1'b0);
    rd(CTL, 8'h00, 2'h0);
    $display("test reset in write done");
    complete_run;
end
endmodule // eeacc_top_test
